//--- design/axis_homing_range_sequencer.sv
// Per-axis homing, range finding and virtual range sequencer with travel interlock.
// Assumes switch inputs are raw pins; motion generator acks a relative move with moveDone.
`timescale 1ns/10ps

module axis_homing_range_sequencer
    import axis_homing_pkg::*;
#(
    parameter int NUM_AXES = 4,
    parameter int TICKS_PER_SEC = CLK_HZ
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire seq_cmd_t cmdCode,
    input wire logic cmdValid,
    input wire logic [NUM_AXES-1:0] cmdAxisSel,
    input wire logic [NUM_AXES-1:0] axisPresent,
    input wire logic [NUM_AXES*POS_W-1:0] vrangeLength,
    input wire axis_cfg_t [NUM_AXES-1:0] axisCfg,
    input wire logic [NUM_AXES-1:0] lowerLimitSwitch,
    input wire logic [NUM_AXES-1:0] upperLimitSwitch,
    input wire logic [NUM_AXES-1:0] moveDone,
    input wire logic [NUM_AXES-1:0] motionFault,
    input wire logic [NUM_AXES*POS_W-1:0] axisPos,
    input wire logic [NUM_AXES-1:0] travelRequest,
    output logic cmdBusy,
    output logic replyValid,
    output logic [NUM_AXES*8-1:0] replyChars,
    output logic [7:0] errNumber,
    output logic errValid,
    output motion_req_t [NUM_AXES-1:0] motionReq,
    output logic [NUM_AXES-1:0] travelAllowed,
    output logic [NUM_AXES-1:0] zeroPosStrobe,
    output logic [NUM_AXES*POS_W-1:0] lowerSoftLimit,
    output logic [NUM_AXES*POS_W-1:0] upperSoftLimit,
    output logic [NUM_AXES-1:0] lowerLimitValid,
    output logic [NUM_AXES-1:0] upperLimitValid,
    output logic [NUM_AXES-1:0] homedStatus,
    output logic [NUM_AXES-1:0] rangedStatus,
    output logic [NUM_AXES-1:0] secureSpeedOn,
    output logic [NUM_AXES-1:0] closedLoopOn,
    output logic [NUM_AXES-1:0] homeDirectionEcho
);
    // ************************************************************
    // Switch synchronisers
    // ************************************************************
    logic [NUM_AXES-1:0] lowMeta_q;
    logic [NUM_AXES-1:0] lowSync_q;
    logic [NUM_AXES-1:0] upMeta_q;
    logic [NUM_AXES-1:0] upSync_q;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lowMeta_q <= '0;
            lowSync_q <= '0;
            upMeta_q <= '0;
            upSync_q <= '0;
        end else begin
            lowMeta_q <= lowerLimitSwitch;
            lowSync_q <= lowMeta_q;
            upMeta_q <= upperLimitSwitch;
            upSync_q <= upMeta_q;
        end
    end

    // ************************************************************
    // Sequencer state
    // ************************************************************
    typedef struct packed {
        seq_state_t st;
        logic isRange;
        logic [7:0] result;
        logic homed;
        logic ranged;
        logic loVal;
        logic upVal;
        logic [POS_W-1:0] loLim;
        logic [POS_W-1:0] upLim;
        logic closed;
        logic zeroPulse;
        motion_req_t req;
    } axis_st_t;

    typedef struct packed {
        logic busy;
        logic reply;
        logic errV;
        logic [7:0] err;
    } top_st_t;

    axis_st_t [NUM_AXES-1:0] ax_q;
    axis_st_t [NUM_AXES-1:0] ax_d;
    top_st_t top_q;
    top_st_t top_d;
    logic [NUM_AXES-1:0] tmrStart;
    logic [NUM_AXES-1:0] tmrClear;
    logic [NUM_AXES-1:0] tmrExpired;
    logic [NUM_AXES-1:0] axisIdle;

    genvar g;
    generate
        for (g = 0; g < NUM_AXES; g++) begin : gAxis
            logic [POS_W-1:0] pos;
            logic swHit;
            logic swEnabled;
            logic [SPEED_W-1:0] seekSpeed;
            logic [SPEED_W-1:0] backSpeed;
            logic [6:0] tmoSec;

            axis_timeout_timer #(
                .TICKS_PER_SEC(TICKS_PER_SEC)
            ) uTimer (
                .core_clk(core_clk),
                .nrst(nrst),
                .start(tmrStart[g]),
                .clear(tmrClear[g]),
                .limitSec(tmoSec),
                .expired(tmrExpired[g])
            );

            assign pos = axisPos[g*POS_W +: POS_W];
            assign axisIdle[g] = (ax_q[g].st == ST_IDLE);

            always_comb begin
                ax_d[g] = ax_q[g];
                ax_d[g].zeroPulse = 1'b0;
                tmrStart[g] = 1'b0;
                tmrClear[g] = 1'b0;
                swHit = ax_q[g].isRange ? upSync_q[g] : lowSync_q[g];
                swEnabled = ax_q[g].isRange ? axisCfg[g].upperEnable
                                            : axisCfg[g].lowerEnable;
                // Speed pair by extended flag
                if (axisCfg[g].extMode) begin
                    seekSpeed = ax_q[g].isRange ? axisCfg[g].rangeSpeed1
                                                : axisCfg[g].homeSpeed1;
                    backSpeed = ax_q[g].isRange ? axisCfg[g].rangeSpeed2
                                                : axisCfg[g].homeSpeed2;
                end else begin
                    seekSpeed = axisCfg[g].travelSpeed;
                    backSpeed = axisCfg[g].retractSpeed;
                end
                // Out-of-range timeout clamps into 1..120
                tmoSec = axisCfg[g].timeoutSec;
                if (tmoSec < 7'(TIMEOUT_MIN_S)) begin
                    tmoSec = 7'(TIMEOUT_MIN_S);
                end else if (tmoSec > 7'(TIMEOUT_MAX_S)) begin
                    tmoSec = 7'(TIMEOUT_MAX_S);
                end

                case (ax_q[g].st)
                    ST_IDLE: begin
                        ax_d[g].req = '0;
                        if (cmdValid && !top_q.busy && cmdAxisSel[g] && axisPresent[g]) begin
                            if (cmdCode == CMD_HOME || cmdCode == CMD_RANGE) begin
                                ax_d[g].isRange = (cmdCode == CMD_RANGE);
                                ax_d[g].result = (cmdCode == CMD_RANGE) ? CH_RANGED
                                                                       : CH_HOMED;
                                ax_d[g].st = ST_SEEK;
                                tmrStart[g] = 1'b1;
                            end
                        end
                    end
                    ST_SEEK: begin
                        if (!swEnabled) begin
                            ax_d[g].st = ST_DONE;
                        end else if (swHit) begin
                            ax_d[g].req.run = 1'b0;
                            ax_d[g].st = ST_BACK;
                        end else begin
                            ax_d[g].req.run = 1'b1;
                            ax_d[g].req.relMove = 1'b0;
                            ax_d[g].req.dirUp = ax_q[g].isRange;
                            ax_d[g].req.speed = seekSpeed;
                        end
                    end
                    ST_BACK: begin
                        // Retract opposite to the seek until the switch releases
                        if (!swHit) begin
                            ax_d[g].req.relMove = 1'b1;
                            ax_d[g].req.run = 1'b1;
                            ax_d[g].req.relDist = ax_q[g].isRange
                                ? axisCfg[g].rangeOffset
                                : axisCfg[g].homeOffset;
                            ax_d[g].st = ST_OFFS;
                        end else begin
                            ax_d[g].req.run = 1'b1;
                            ax_d[g].req.dirUp = !ax_q[g].isRange;
                            ax_d[g].req.speed = backSpeed;
                        end
                    end
                    ST_OFFS: begin
                        if (moveDone[g]) begin
                            ax_d[g].req = '0;
                            ax_d[g].st = ST_DONE;
                            if (!ax_q[g].isRange) begin
                                ax_d[g].homed = 1'b1;
                                // Mode 1 keeps the power-up zero
                                if (axisCfg[g].originMode != 2'h1) begin
                                    ax_d[g].zeroPulse = 1'b1;
                                end
                                if (!axisCfg[g].limitKeep) begin
                                    ax_d[g].loVal = 1'b1;
                                    ax_d[g].loLim = (axisCfg[g].originMode != 2'h1)
                                        ? '0 : pos;
                                end
                            end else begin
                                ax_d[g].ranged = 1'b1;
                                if (!axisCfg[g].limitKeep) begin
                                    ax_d[g].upVal = 1'b1;
                                    ax_d[g].upLim = pos;
                                end
                            end
                        end
                    end
                    default: begin
                        ax_d[g].st = ST_IDLE;
                        tmrClear[g] = 1'b1;
                    end
                endcase

                // Fault or timeout abort from any moving state
                if (ax_q[g].st == ST_SEEK || ax_q[g].st == ST_BACK || ax_q[g].st == ST_OFFS)
                begin
                    if (tmrExpired[g]) begin
                        ax_d[g].req = '0;
                        ax_d[g].result = CH_TIMEOUT;
                        ax_d[g].st = ST_DONE;
                    end else if (motionFault[g]) begin
                        ax_d[g].req = '0;
                        ax_d[g].result = CH_ERROR;
                        ax_d[g].st = ST_DONE;
                    end
                end

                // Virtual range: no motion, no reply
                if (axisIdle[g] && cmdValid && !top_q.busy && cmdCode == CMD_VRANGE
                    && cmdAxisSel[g] && axisPresent[g] && ax_q[g].homed) begin
                    ax_d[g].ranged = 1'b1;
                    ax_d[g].upVal = 1'b1;
                    ax_d[g].upLim = ax_q[g].loLim + vrangeLength[g*POS_W +: POS_W];
                end

                // Closed loop needs the encoder mask
                ax_d[g].closed = axisCfg[g].encoderMask
                    && (axisCfg[g].originMode != 2'h0 || ax_d[g].homed);
            end

            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    ax_q[g] <= '0;
                end else begin
                    ax_q[g] <= ax_d[g];
                end
            end

            assign replyChars[g*8 +: 8] = axisPresent[g] && cmdAxisSel[g] ? ax_q[g].result
                                                                          : CH_ABSENT;
            assign motionReq[g] = ax_q[g].req;
            // Secure speed stays until homing plus range, or homing alone with the upper switch out of use; off with both switches out of use
            assign secureSpeedOn[g] = (axisCfg[g].lowerEnable || axisCfg[g].upperEnable)
                && !(ax_q[g].homed && (ax_q[g].ranged || !axisCfg[g].upperEnable));
            assign travelAllowed[g] = travelRequest[g]
                && (!axisCfg[g].homeRequired || ax_q[g].homed);
            assign zeroPosStrobe[g] = ax_q[g].zeroPulse;
            assign lowerSoftLimit[g*POS_W +: POS_W] = ax_q[g].loLim;
            assign upperSoftLimit[g*POS_W +: POS_W] = ax_q[g].upLim;
            assign lowerLimitValid[g] = ax_q[g].loVal;
            assign upperLimitValid[g] = ax_q[g].upVal;
            assign homedStatus[g] = ax_q[g].homed;
            assign rangedStatus[g] = ax_q[g].ranged;
            assign closedLoopOn[g] = ax_q[g].closed;
            assign homeDirectionEcho[g] = axisCfg[g].homeDirection;
        end
    endgenerate

    // ************************************************************
    // Command bookkeeping and reply
    // ************************************************************
    logic allIdleNext;
    logic vrReject;

    always_comb begin
        allIdleNext = 1'b1;
        vrReject = 1'b0;
        for (int i = 0; i < NUM_AXES; i++) begin
            if (ax_d[i].st != ST_IDLE) begin
                allIdleNext = 1'b0;
            end
            if (cmdAxisSel[i] && axisPresent[i] && !ax_q[i].homed) begin
                vrReject = 1'b1;
            end
        end
        top_d = top_q;
        top_d.reply = 1'b0;
        top_d.errV = 1'b0;
        if (cmdValid && !top_q.busy) begin
            if (cmdCode == CMD_VRANGE) begin
                top_d.err = vrReject ? ERR_NOT_HOMED : 8'h00;
                top_d.errV = 1'b1;
            end else if (cmdCode == CMD_HOME || cmdCode == CMD_RANGE) begin
                top_d.busy = 1'b1;
            end
        // Empty selection answers at once rather than holding busy forever
        end else if (top_q.busy && allIdleNext) begin
            top_d.busy = 1'b0;
            top_d.reply = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            top_q <= '0;
        end else begin
            top_q <= top_d;
        end
    end

    assign cmdBusy = top_q.busy;
    assign replyValid = top_q.reply;
    assign errNumber = top_q.err;
    assign errValid = top_q.errV;
endmodule : axis_homing_range_sequencer

//--- design/axis_homing_pkg.sv
// Shared types and constants for the per-axis homing and range sequencer.
// Assumes one 25 MHz core clock; positions are signed steps from the motion side.
package axis_homing_pkg;

    localparam int CLK_HZ = 25000000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int TIMEOUT_MIN_S = 1;
    localparam int TIMEOUT_MAX_S = 120;
    localparam logic [6:0] TIMEOUT_RESET_S = 7'h28;
    localparam int POS_W = 32;
    localparam int SPEED_W = 16;
    localparam logic [POS_W-1:0] OFFSET_RESET = 32'h0;
    localparam logic [1:0] ORIGIN_MODE_RESET = 2'h0;

    localparam logic [7:0] CH_HOMED = 8'h41;
    localparam logic [7:0] CH_RANGED = 8'h44;
    localparam logic [7:0] CH_ERROR = 8'h45;
    localparam logic [7:0] CH_TIMEOUT = 8'h54;
    localparam logic [7:0] CH_ABSENT = 8'h2d;
    localparam logic [7:0] ERR_NOT_HOMED = 8'h02;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SEEK = 3'b001,
        ST_BACK = 3'b011,
        ST_OFFS = 3'b010,
        ST_DONE = 3'b110
    } seq_state_t;

    typedef enum logic [1:0] {
        CMD_NONE = 2'h0,
        CMD_HOME = 2'h1,
        CMD_RANGE = 2'h2,
        CMD_VRANGE = 2'h3
    } seq_cmd_t;

    // Per-axis setting bundle
    typedef struct packed {
        logic lowerEnable;
        logic upperEnable;
        logic extMode;
        logic limitKeep;
        logic [1:0] originMode;
        logic encoderMask;
        logic homeRequired;
        logic homeDirection;
        logic [6:0] timeoutSec;
        logic [POS_W-1:0] homeOffset;
        logic [POS_W-1:0] rangeOffset;
        logic [SPEED_W-1:0] travelSpeed;
        logic [SPEED_W-1:0] retractSpeed;
        logic [SPEED_W-1:0] homeSpeed1;
        logic [SPEED_W-1:0] homeSpeed2;
        logic [SPEED_W-1:0] rangeSpeed1;
        logic [SPEED_W-1:0] rangeSpeed2;
    } axis_cfg_t;

    // Motion request toward the profile generator
    typedef struct packed {
        logic run;
        logic dirUp;
        logic [SPEED_W-1:0] speed;
        logic relMove;
        logic [POS_W-1:0] relDist;
    } motion_req_t;

endpackage : axis_homing_pkg

//--- design/axis_timeout_timer.sv
// Seconds timeout counter for one axis sequence.
// Assumes start is a single-cycle pulse; clear stops it at any time.
`timescale 1ns/10ps
module axis_timeout_timer
    import axis_homing_pkg::*;
#(
    parameter int TICKS_PER_SEC = CLK_HZ
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic clear,
    input wire logic [6:0] limitSec,
    output logic expired
);
    typedef struct packed {
        logic run;
        logic [31:0] tick;
        logic [6:0] sec;
        logic exp;
    } tmr_t;

    tmr_t s_q;
    tmr_t s_d;

    always_comb begin
        s_d = s_q;
        if (clear) begin
            s_d = '0;
        end else if (start) begin
            s_d.run = 1'b1;
            s_d.tick = '0;
            s_d.sec = '0;
            s_d.exp = 1'b0;
        end else if (s_q.run) begin
            if (s_q.tick == 32'(TICKS_PER_SEC - 1)) begin
                s_d.tick = '0;
                s_d.sec = s_q.sec + 7'h1;
                if (s_q.sec + 7'h1 >= limitSec) begin
                    s_d.exp = 1'b1;
                    s_d.run = 1'b0;
                end
            end else begin
                s_d.tick = s_q.tick + 32'h1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign expired = s_q.exp;
endmodule : axis_timeout_timer

//--- tb/axis_homing_monitor.sv
// Port checker for the homing and range sequencer.
// Assumes bind from the bench, which holds cmdCode and cmdAxisSel while busy.
`timescale 1ns/10ps
module axis_homing_monitor
    import axis_homing_pkg::*;
#(
    parameter int NUM_AXES = 4
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire seq_cmd_t cmdCode,
    input wire logic cmdValid,
    input wire logic cmdBusy,
    input wire logic [NUM_AXES-1:0] cmdAxisSel,
    input wire logic [NUM_AXES-1:0] axisPresent,
    input wire axis_cfg_t [NUM_AXES-1:0] axisCfg,
    input wire logic replyValid,
    input wire logic [NUM_AXES*8-1:0] replyChars,
    input wire logic [7:0] errNumber,
    input wire logic errValid,
    input wire motion_req_t [NUM_AXES-1:0] motionReq,
    input wire logic [NUM_AXES-1:0] travelAllowed,
    input wire logic [NUM_AXES-1:0] zeroPosStrobe,
    input wire logic [NUM_AXES-1:0] homedStatus,
    input wire logic [NUM_AXES-1:0] closedLoopOn,
    input wire logic [NUM_AXES-1:0] homeDirectionEcho
);
    // ****************
    // Checks
    // ****************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    busy_cause_a: assert property ($rose(cmdBusy) |-> $past(cmdValid))
        else $error("busy rose without a command");
    vrange_quiet_a: assert property ((errValid |-> cmdCode == CMD_VRANGE)
        and (replyValid |-> cmdCode != CMD_VRANGE)) else $error("wrong answer kind");
    err_code_a: assert property (errValid |->
        (errNumber == ERR_NOT_HOMED) == (|(cmdAxisSel & axisPresent & ~homedStatus)))
        else $error("virtual range error number wrong");
    for (genvar i = 0; i < NUM_AXES; i++) begin : g_ax
        wire motion_req_t r = motionReq[i];
        wire axis_cfg_t c = axisCfg[i];
        home_speed_a: assert property (
            cmdBusy && cmdCode == CMD_HOME && r.run && !r.relMove |-> r.speed ==
            (r.dirUp ? (c.extMode ? c.homeSpeed2 : c.retractSpeed)
            : (c.extMode ? c.homeSpeed1 : c.travelSpeed))) else $error("homing speed wrong");
        range_speed_a: assert property (
            cmdBusy && cmdCode == CMD_RANGE && r.run && !r.relMove |-> r.speed ==
            (r.dirUp ? (c.extMode ? c.rangeSpeed1 : c.travelSpeed)
            : (c.extMode ? c.rangeSpeed2 : c.retractSpeed))) else $error("range speed wrong");
        offset_move_a: assert property (
            cmdBusy && r.run && r.relMove |->
            r.relDist == (cmdCode == CMD_HOME ? c.homeOffset : c.rangeOffset))
            else $error("offset distance wrong");
        skip_move_a: assert property (
            cmdBusy && (cmdCode == CMD_HOME ? !c.lowerEnable : !c.upperEnable) |-> !r.run)
            else $error("motion on disabled switch");
        absent_char_a: assert property (
            replyValid && !(axisPresent[i] && cmdAxisSel[i]) |->
            replyChars[i*8+:8] == CH_ABSENT) else $error("absent axis char wrong");
        travel_block_a: assert property (
            c.homeRequired && !homedStatus[i] |-> !travelAllowed[i])
            else $error("travel not blocked");
        dir_echo_a: assert property (homeDirectionEcho[i] == c.homeDirection)
            else $error("direction echo wrong");
        loop_mask_a: assert property (closedLoopOn[i] |-> $past(c.encoderMask))
            else $error("closed loop without encoder");
        zero_mode_a: assert property (zeroPosStrobe[i] |-> c.originMode != 2'h1)
            else $error("zero set in keep mode");
    end
endmodule : axis_homing_monitor

//--- tb/stage_axes_model.sv
// Stage axes: step counters with lower and upper switch pins.
// Assumes motion requests from the sequencer; stall freezes travel.
`timescale 1ns/10ps
module stage_axes_model
    import axis_homing_pkg::*;
#(
    parameter int N = 2
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic stall,
    input wire motion_req_t [N-1:0] motionReq,
    input wire logic [N-1:0] zeroPosStrobe,
    output logic [N-1:0] lowerLimitSwitch,
    output logic [N-1:0] upperLimitSwitch,
    output logic [N-1:0] moveDone,
    output logic [N*POS_W-1:0] axisPos
);
    // ****************
    // Axis motion
    // ****************
    int pos [N];
    int cnt [N];
    always_ff @(posedge core_clk or negedge nrst) begin
        for (int i = 0; i < N; i++) begin
            if (!nrst) begin
                pos[i] <= 0;
                cnt[i] <= 0;
            end else begin
                cnt[i] <= (motionReq[i].run && motionReq[i].relMove) ? cnt[i] + 1 : 0;
                if (zeroPosStrobe[i])
                    pos[i] <= 0;
                else if (motionReq[i].run && !motionReq[i].relMove && !stall)
                    pos[i] <= motionReq[i].dirUp ? pos[i] + 1 : pos[i] - 1;
            end
        end
    end
    // Offset move ends after a few cycles; one pulse only
    always_comb begin
        for (int i = 0; i < N; i++) begin
            lowerLimitSwitch[i] = pos[i] <= -20;
            upperLimitSwitch[i] = pos[i] >= 30;
            moveDone[i] = cnt[i] == 3;
            axisPos[i*POS_W+:POS_W] = pos[i];
        end
    end
endmodule : stage_axes_model

//--- tb/axis_homing_range_sequencer_tb_top.sv
// Bench for the homing and range sequencer: axis zero fitted, axis one absent.
// Assumes the stage model on the far side and a shortened second.
`timescale 1ns/10ps
module axis_homing_range_sequencer_tb_top;
    import axis_homing_pkg::*;
    // ****************
    // Bench
    // ****************
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    seq_cmd_t cmdCode = CMD_NONE;
    logic cmdValid = 1'b0;
    logic stall = 1'b0;
    logic [1:0] cmdAxisSel = 2'h1;
    logic [1:0] axisPresent = 2'h1;
    logic [1:0] motionFault = 2'h0;
    logic [1:0] travelRequest = 2'h3;
    logic [63:0] vrangeLength = 64'h0;
    axis_cfg_t [1:0] axisCfg = '0;
    logic cmdBusy, replyValid, errValid;
    logic [15:0] replyChars;
    logic [7:0] errNumber;
    motion_req_t [1:0] motionReq;
    logic [1:0] travelAllowed, zeroPosStrobe, lowerLimitValid, upperLimitValid, homedStatus;
    logic [1:0] rangedStatus, secureSpeedOn, closedLoopOn, homeDirectionEcho, moveDone;
    logic [1:0] lowerLimitSwitch, upperLimitSwitch;
    logic [63:0] axisPos, lowerSoftLimit, upperSoftLimit;
    int failures = 0;
    int tests_run = 0;
    always #20 core_clk = ~core_clk;
    axis_homing_range_sequencer #(.NUM_AXES(2), .TICKS_PER_SEC(10)) i_axis_homing_range_sequencer (
        .core_clk(core_clk), .nrst(nrst), .cmdCode(cmdCode), .cmdValid(cmdValid),
        .cmdAxisSel(cmdAxisSel), .axisPresent(axisPresent), .vrangeLength(vrangeLength),
        .axisCfg(axisCfg), .lowerLimitSwitch(lowerLimitSwitch), .moveDone(moveDone),
        .upperLimitSwitch(upperLimitSwitch), .motionFault(motionFault), .axisPos(axisPos),
        .travelRequest(travelRequest), .cmdBusy(cmdBusy), .replyValid(replyValid),
        .replyChars(replyChars), .errNumber(errNumber), .errValid(errValid),
        .motionReq(motionReq), .travelAllowed(travelAllowed), .zeroPosStrobe(zeroPosStrobe),
        .lowerSoftLimit(lowerSoftLimit), .upperSoftLimit(upperSoftLimit),
        .lowerLimitValid(lowerLimitValid), .upperLimitValid(upperLimitValid),
        .homedStatus(homedStatus), .rangedStatus(rangedStatus), .secureSpeedOn(secureSpeedOn),
        .closedLoopOn(closedLoopOn), .homeDirectionEcho(homeDirectionEcho));
    stage_axes_model #(.N(2)) i_stage_axes_model (
        .core_clk(core_clk), .nrst(nrst), .stall(stall), .motionReq(motionReq),
        .zeroPosStrobe(zeroPosStrobe), .lowerLimitSwitch(lowerLimitSwitch),
        .upperLimitSwitch(upperLimitSwitch), .moveDone(moveDone), .axisPos(axisPos));
    task automatic give_verdict();
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    task automatic check(logic [63:0] got, logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Holds code and selection after the pulse; the checker relies on it
    task automatic run_cmd(seq_cmd_t c, logic [1:0] sel);
        @(negedge core_clk);
        cmdCode = c;
        cmdAxisSel = sel;
        cmdValid = 1'b1;
        for (int k = 0; k <= 3000; k++) begin
            if (k == 3000) begin
                failures++;
                $display("CHECK FAILED t=%0t no answer", $time);
                give_verdict();
            end
            @(negedge core_clk);
            cmdValid = 1'b0;
            if (replyValid === 1'b1 || errValid === 1'b1)
                break;
        end
    endtask : run_cmd
    function automatic logic [63:0] exp_reply(logic [7:0] c0);
        return {48'h0, CH_ABSENT, c0};
    endfunction : exp_reply
    function automatic axis_cfg_t rand_cfg(int mode);
        logic [191:0] r;
        axis_cfg_t c;
        r = {$urandom(), $urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
        c = r[175:0];
        c.lowerEnable = 1'b1;
        c.upperEnable = 1'b1;
        c.extMode = mode[0];
        c.limitKeep = 1'b0;
        c.originMode = mode[1:0];
        c.encoderMask = 1'b1;
        c.homeRequired = 1'b0;
        c.timeoutSec = TIMEOUT_RESET_S;
        c.homeOffset = {24'h0, r[7:0]};
        c.rangeOffset = {24'h0, r[15:8]};
        return c;
    endfunction : rand_cfg
    initial begin
        logic [7:0] expc [5];
        expc = '{CH_HOMED, CH_RANGED, CH_TIMEOUT, CH_TIMEOUT, CH_ERROR};
        void'($urandom(26489));
        axisCfg[0] = rand_cfg(0);
        axisCfg[0].homeRequired = 1'b1;
        axisCfg[1] = rand_cfg(2);
        axisCfg[1].encoderMask = 1'b0;
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        nrst = 1'b1;
        check(travelAllowed, 2'h2);
        check(homeDirectionEcho, {axisCfg[1].homeDirection, axisCfg[0].homeDirection});
        check(closedLoopOn, 2'h0);
        vrangeLength = {32'h0, 24'h0, 8'($urandom())};
        run_cmd(CMD_VRANGE, 2'h1);
        check(errNumber, ERR_NOT_HOMED);
        check(rangedStatus, 2'h0);
        for (int m = 0; m < 3; m++) begin
            @(negedge core_clk);
            axisCfg[0] = rand_cfg(m);
            run_cmd(CMD_HOME, 2'h3);
            check(replyChars, exp_reply(CH_HOMED));
            if (m != 1)
                check(lowerSoftLimit[31:0], 32'h0);
            check({lowerLimitValid[0], homedStatus[0], closedLoopOn}, 4'hd);
            run_cmd(CMD_RANGE, 2'h3);
            check(replyChars, exp_reply(CH_RANGED));
            check({rangedStatus[0], upperLimitValid[0], secureSpeedOn[0]}, 3'h6);
        end
        run_cmd(CMD_VRANGE, 2'h1);
        check(errNumber, 8'h0);
        check(upperSoftLimit[31:0], vrangeLength[31:0]);
        run_cmd(CMD_HOME, 2'h2);
        check(replyChars, exp_reply(CH_ABSENT));
        // Disabled switches, stalled axis with one second, then a fault
        for (int t = 0; t < 5; t++) begin
            @(negedge core_clk);
            axisCfg[0] = rand_cfg(0);
            axisCfg[0].lowerEnable = t != 0;
            axisCfg[0].upperEnable = t != 1;
            axisCfg[0].timeoutSec = 7'h1;
            stall = t inside {2, 3};
            motionFault = (t == 4) ? 2'h1 : 2'h0;
            run_cmd(t[0] ? CMD_RANGE : CMD_HOME, 2'h3);
            check(replyChars, exp_reply(expc[t]));
        end
        give_verdict();
    end
endmodule : axis_homing_range_sequencer_tb_top
bind axis_homing_range_sequencer axis_homing_monitor #(.NUM_AXES(NUM_AXES)) i_axis_homing_monitor (
    .core_clk(core_clk), .nrst(nrst), .cmdCode(cmdCode), .cmdValid(cmdValid),
    .cmdBusy(cmdBusy), .cmdAxisSel(cmdAxisSel), .axisPresent(axisPresent), .axisCfg(axisCfg),
    .replyValid(replyValid), .replyChars(replyChars), .errNumber(errNumber),
    .errValid(errValid), .motionReq(motionReq), .travelAllowed(travelAllowed),
    .zeroPosStrobe(zeroPosStrobe), .homedStatus(homedStatus), .closedLoopOn(closedLoopOn),
    .homeDirectionEcho(homeDirectionEcho));
